// ---- design/asq_pkg.sv ----
// Constants and types shared by the scan/select conversion sequencer
`default_nettype none

package asq_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_CHAN = 8;
    localparam int RES_W = 10;
    localparam int CNT_W = 9;
    localparam logic [2:0] LAST_CHAN = 3'h7;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int HI_START_POS = 4;
    localparam int LO_RUN_POS = 4;
    localparam int IRQ_SCAN_DONE_POS = 0;
    localparam int IRQ_SINGLE_DONE_POS = 1;
    localparam int IRQ_SCAN_EN_POS = 2;
    localparam int IRQ_SINGLE_EN_POS = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] HI_RESET = 8'h88;
    localparam logic [7:0] LO_RESET = 8'h88;
    localparam logic [7:0] IRQ_CTRL_RESET = 8'hf0;
    localparam logic [7:0] HI_FILL_ONES = 8'h88;
    localparam logic [7:0] LO_FILL_ONES = 8'h88;
    localparam logic [7:0] IRQ_FILL_ONES = 8'hf0;
    localparam logic [15:0] CONV_VECTOR = 16'h0044;

    // ------------------------------------------------------------
    // Per-channel clock budget, indexed by length code
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] LEN_TAB [0:3] = '{9'h180, 9'h100, 9'h0c0, 9'h080};
    localparam logic [CNT_W-1:0] SAMP_TAB [0:3] = '{9'h0e9, 9'h09b, 9'h074, 9'h04d};
    localparam logic [CNT_W-1:0] CONV_TAB [0:3] = '{9'h050, 9'h036, 9'h029, 9'h01c};
    localparam logic [CNT_W-1:0] OTHER_TAB [0:3] = '{9'h047, 9'h02f, 9'h023, 9'h017};

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SCAN = 2'b01,
        ST_SELECT = 2'b10
    } asq_state_t;

    typedef struct packed {
        logic fill7;
        logic [1:0] len_sel;
        logic start;
        logic fill3;
        logic [2:0] chan;
    } asq_hi_t;

    typedef struct packed {
        logic fill7;
        logic repeat_sel;
        logic trig_sel;
        logic run;
        logic fill3;
        logic [2:0] start_chan;
    } asq_lo_t;

endpackage : asq_pkg

`default_nettype wire

// ---- design/asq_sequencer.sv ----
// Scan/select sequencer for an 8-channel 10-bit successive-approximation converter
//
// Summary of operation
// RL1 - Software clears single flag before select start
// RL2 - Irq-control bit 3 gates single-done interrupt
// RL3 - High bits 0-2 choose select channel
// RL4 - High bits 5-6 set clocks per channel
// RL5 - Start bit 1 starts, 0 aborts select
// RL6 - Two modes only: scan and select
// RL7 - Scan converts ascending from start to 7
// RL8 - After channel 7 stop or restart
// RL9 - Select start abandons current scan channel
// RL10 - Scan resumes, reconverting interrupted channel fully
// RL11 - Codes give 384, 256, 192, 128 clocks
// RL12 - Each length splits sampling, conversion, overhead
// RL13 - Either cause sets the request flag
// RL14 - Enable flag gates a pending request
// RL15 - Two priority bits choose priority level
// RL16 - Both causes share flag and vector 0044
// RL17 - Scan flag sets at channel 7, sticky
// RL18 - Run bit 1 starts scan, 0 stops
// RL19 - One 10-bit result register per channel
// RL20 - Result written with its completion flag
`default_nettype none

module asq_sequencer (
    input wire logic clock,
    input wire logic rst,
    input wire logic hi_wr,
    input wire logic [7:0] hi_wdata,
    output logic [7:0] hi_rdata,
    input wire logic lo_wr,
    input wire logic [7:0] lo_wdata,
    output logic [7:0] lo_rdata,
    input wire logic irq_ctrl_wr,
    input wire logic [7:0] irq_ctrl_wdata,
    output logic [7:0] irq_ctrl_rdata,
    input wire logic irq_req_clear,
    input wire logic conv_irq_enable,
    input wire logic conv_prio_bit0,
    input wire logic conv_prio_bit1,
    output logic conv_irq_request,
    output logic conv_irq_out,
    output logic [1:0] conv_irq_prio,
    output logic [15:0] conv_irq_vector,
    input wire logic [asq_pkg::RES_W-1:0] fe_result,
    output logic [2:0] fe_chan,
    output logic fe_sample,
    output logic fe_convert,
    output logic [asq_pkg::RES_W-1:0] conv_result_reg [0:asq_pkg::NUM_CHAN-1]
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    asq_pkg::asq_hi_t hi_q;
    asq_pkg::asq_lo_t lo_q;
    asq_pkg::asq_hi_t hi_w;
    asq_pkg::asq_lo_t lo_w;
    asq_pkg::asq_state_t state_q;
    logic [2:0] chan_q;
    logic [2:0] resume_chan_q;
    logic [asq_pkg::CNT_W-1:0] cnt_q;
    logic scan_done_q;
    logic single_done_q;
    logic scan_irq_en_q;
    logic single_irq_en_q;
    logic req_q;
    logic [asq_pkg::RES_W-1:0] fe_meta_q;
    logic [asq_pkg::RES_W-1:0] fe_sync_q;
    logic [asq_pkg::CNT_W-1:0] len_last;
    logic [asq_pkg::CNT_W-1:0] samp_end;
    logic [asq_pkg::CNT_W-1:0] conv_end_cnt;
    logic busy;
    logic conv_end;
    logic sel_start;
    logic sel_abort;
    logic scan_go;
    logic scan_halt;
    logic run_next;
    logic scan_cycle_done;
    logic single_finish;
    logic scan_wrap_stop;

    assign hi_w = asq_pkg::asq_hi_t'(hi_wdata);
    assign lo_w = asq_pkg::asq_lo_t'(lo_wdata);

    // ------------------------------------------------------------
    // Timing budget
    // ------------------------------------------------------------
    // Length chosen live, so a change of code mid-channel takes effect at once
    assign len_last = asq_pkg::LEN_TAB[hi_q.len_sel] - 9'h001; // see RL4 see RL11
    assign samp_end = asq_pkg::SAMP_TAB[hi_q.len_sel]; // see RL12
    assign conv_end_cnt = asq_pkg::SAMP_TAB[hi_q.len_sel] + asq_pkg::CONV_TAB[hi_q.len_sel];

    assign busy = (state_q != asq_pkg::ST_IDLE);
    assign conv_end = busy && (cnt_q == len_last);

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // A second start while a select is busy is ignored, not restarted
    assign sel_start = hi_wr && hi_w.start && (state_q != asq_pkg::ST_SELECT); // see RL5
    assign sel_abort = hi_wr && !hi_w.start && (state_q == asq_pkg::ST_SELECT); // see RL5
    assign scan_go = lo_wr && lo_w.run && !lo_q.run; // see RL18
    assign scan_halt = lo_wr && !lo_w.run; // see RL18
    assign run_next = lo_wr ? lo_w.run : lo_q.run;

    assign scan_cycle_done = (state_q == asq_pkg::ST_SCAN) && conv_end
        && (chan_q == asq_pkg::LAST_CHAN) && !scan_halt && !sel_start;
    assign scan_wrap_stop = scan_cycle_done && !lo_q.repeat_sel; // see RL8
    assign single_finish = (state_q == asq_pkg::ST_SELECT) && conv_end && !sel_abort;

    // ------------------------------------------------------------
    // Front-end result synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            fe_meta_q <= '0;
            fe_sync_q <= '0;
        end else begin
            fe_meta_q <= fe_result;
            fe_sync_q <= fe_meta_q;
        end
    end

    // ------------------------------------------------------------
    // High control register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            hi_q <= asq_pkg::asq_hi_t'(asq_pkg::HI_RESET);
        end else begin
            if (hi_wr) begin
                hi_q.chan <= hi_w.chan; // see RL3
                hi_q.len_sel <= hi_w.len_sel; // see RL4
            end
            if (sel_start) begin
                hi_q.start <= 1'b1;
            end else if (sel_abort || single_finish) begin
                hi_q.start <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Low control register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            lo_q <= asq_pkg::asq_lo_t'(asq_pkg::LO_RESET);
        end else begin
            if (lo_wr) begin
                lo_q.start_chan <= lo_w.start_chan;
                lo_q.trig_sel <= lo_w.trig_sel;
                lo_q.repeat_sel <= lo_w.repeat_sel;
                lo_q.run <= lo_w.run; // see RL18
            end
            // Stop after channel 7 beats a same-cycle run write, so state and bit agree
            if (scan_wrap_stop) begin
                lo_q.run <= 1'b0; // see RL8
            end
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Only idle, scan and select exist; select always outranks scan
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= asq_pkg::ST_IDLE;
            chan_q <= '0;
            cnt_q <= '0;
        end else begin
            case (state_q) // see RL6
                asq_pkg::ST_IDLE: begin
                    cnt_q <= '0;
                    if (sel_start) begin
                        state_q <= asq_pkg::ST_SELECT;
                        chan_q <= hi_w.chan; // see RL3
                    end else if (scan_go) begin
                        state_q <= asq_pkg::ST_SCAN;
                        chan_q <= lo_w.start_chan; // see RL7
                    end
                end
                asq_pkg::ST_SCAN: begin
                    if (sel_start) begin
                        state_q <= asq_pkg::ST_SELECT; // see RL9
                        chan_q <= hi_w.chan;
                        cnt_q <= '0;
                    end else if (scan_halt) begin
                        state_q <= asq_pkg::ST_IDLE; // see RL18
                        cnt_q <= '0;
                    end else if (conv_end) begin
                        cnt_q <= '0;
                        if (chan_q == asq_pkg::LAST_CHAN) begin
                            if (lo_q.repeat_sel) begin
                                chan_q <= lo_q.start_chan; // see RL8
                            end else begin
                                state_q <= asq_pkg::ST_IDLE; // see RL8
                            end
                        end else begin
                            chan_q <= chan_q + 3'h1; // see RL7
                        end
                    end else begin
                        cnt_q <= cnt_q + 9'h001;
                    end
                end
                asq_pkg::ST_SELECT: begin
                    if (sel_abort || conv_end) begin
                        cnt_q <= '0;
                        if (run_next) begin
                            state_q <= asq_pkg::ST_SCAN; // see RL10
                            chan_q <= scan_go ? lo_w.start_chan : resume_chan_q;
                        end else begin
                            state_q <= asq_pkg::ST_IDLE;
                        end
                    end else begin
                        cnt_q <= cnt_q + 9'h001;
                    end
                end
                default: begin
                    state_q <= asq_pkg::ST_IDLE;
                    cnt_q <= '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Channel to resume after a select
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            resume_chan_q <= '0;
        end else if (sel_start && state_q == asq_pkg::ST_SCAN) begin
            resume_chan_q <= chan_q; // see RL10
        end else if (scan_go) begin
            resume_chan_q <= lo_w.start_chan;
        end
    end

    // ------------------------------------------------------------
    // Completion flags and interrupt enables
    // ------------------------------------------------------------
    // Hardware set beats a software write of 0 in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            scan_done_q <= 1'b0;
            single_done_q <= 1'b0;
            scan_irq_en_q <= 1'b0;
            single_irq_en_q <= 1'b0;
        end else begin
            if (irq_ctrl_wr) begin
                scan_irq_en_q <= irq_ctrl_wdata[asq_pkg::IRQ_SCAN_EN_POS];
                single_irq_en_q <= irq_ctrl_wdata[asq_pkg::IRQ_SINGLE_EN_POS]; // see RL2
            end
            if (scan_cycle_done) begin
                scan_done_q <= 1'b1; // see RL17
            end else if (irq_ctrl_wr) begin
                scan_done_q <= irq_ctrl_wdata[asq_pkg::IRQ_SCAN_DONE_POS];
            end
            if (single_finish) begin
                single_done_q <= 1'b1;
            end else if (irq_ctrl_wr) begin
                single_done_q <= irq_ctrl_wdata[asq_pkg::IRQ_SINGLE_DONE_POS]; // see RL1
            end
        end
    end

    // ------------------------------------------------------------
    // Shared interrupt request
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            req_q <= 1'b0;
        end else if ((scan_cycle_done && scan_irq_en_q)
                || (single_finish && single_irq_en_q)) begin
            req_q <= 1'b1; // see RL13 see RL16 see RL2
        end else if (irq_req_clear) begin
            req_q <= 1'b0;
        end
    end

    assign conv_irq_request = req_q;
    assign conv_irq_out = req_q && conv_irq_enable; // see RL14
    assign conv_irq_prio = {conv_prio_bit1, conv_prio_bit0}; // see RL15
    assign conv_irq_vector = asq_pkg::CONV_VECTOR; // see RL16

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    // Written on each completed channel's last edge, the edge that also sets the flag for a select or scan channel 7
    for (genvar i = 0; i < asq_pkg::NUM_CHAN; i++) begin : g_result
        always_ff @(posedge clock) begin
            if (rst) begin
                conv_result_reg[i] <= '0;
            end else if (conv_end && !sel_abort && !(state_q == asq_pkg::ST_SCAN
                    && (scan_halt || sel_start)) && chan_q == 3'(i)) begin
                conv_result_reg[i] <= fe_sync_q; // see RL19 see RL20
            end
        end
    end

    // ------------------------------------------------------------
    // Front-end phase controls
    // ------------------------------------------------------------
    // Overhead clocks follow conversion; front end is idle in them
    assign fe_chan = chan_q;
    assign fe_sample = busy && (cnt_q < samp_end); // see RL12
    assign fe_convert = busy && (cnt_q >= samp_end) && (cnt_q < conv_end_cnt); // see RL12

    // ------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------
    assign hi_rdata = 8'(hi_q) | asq_pkg::HI_FILL_ONES;
    assign lo_rdata = 8'(lo_q) | asq_pkg::LO_FILL_ONES;
    assign irq_ctrl_rdata = asq_pkg::IRQ_FILL_ONES
        | {4'h0, single_irq_en_q, scan_irq_en_q, single_done_q, scan_done_q};

endmodule : asq_sequencer

`default_nettype wire

// ---- verif/asq_seq_asserts.sv ----
// Port-level assertion checker for the scan/select sequencer
`default_nettype none
module asq_seq_asserts (
    input wire logic clock,
    input wire logic rst,
    input wire logic hi_wr,
    input wire logic [7:0] hi_wdata,
    input wire logic [7:0] hi_rdata,
    input wire logic lo_wr,
    input wire logic [7:0] lo_rdata,
    input wire logic irq_ctrl_wr,
    input wire logic [7:0] irq_ctrl_rdata,
    input wire logic irq_req_clear,
    input wire logic conv_irq_enable,
    input wire logic conv_prio_bit0,
    input wire logic conv_prio_bit1,
    input wire logic conv_irq_request,
    input wire logic conv_irq_out,
    input wire logic [1:0] conv_irq_prio,
    input wire logic [15:0] conv_irq_vector,
    input wire logic [2:0] fe_chan,
    input wire logic fe_sample,
    input wire logic fe_convert
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [8:0] samp_n;
    logic [8:0] busy_n;
    // A high or low control write may restart a channel, so the count restarts too
    always_ff @(posedge clock) begin
        samp_n <= (!rst && fe_sample && !hi_wr && !lo_wr) ? samp_n + 9'h1 : 9'h0;
        busy_n <= (!rst && hi_rdata[4]) ? busy_n + 9'h1 : 9'h0;
    end
    a_vector_fixed: assert property (conv_irq_vector == 16'h0044)
        else $error("vector wrong");
    a_irq_gate: assert property (conv_irq_out == (conv_irq_request && conv_irq_enable))
        else $error("irq out not gated");
    a_prio_pass: assert property (conv_irq_prio == {conv_prio_bit1, conv_prio_bit0})
        else $error("priority wrong");
    a_req_sticky: assert property (conv_irq_request && !irq_req_clear |=> conv_irq_request)
        else $error("request lost");
    a_single_irq: assert property ($fell(hi_rdata[4]) && !$past(hi_wr) && irq_ctrl_rdata[3]
        |-> conv_irq_request && irq_ctrl_rdata[1]) else $error("single end no request");
    a_samp_len: assert property ($rose(fe_convert)
        |-> samp_n == asq_pkg::SAMP_TAB[hi_rdata[6:5]]) else $error("sampling length");
    a_sel_len: assert property ($fell(hi_rdata[4]) && !$past(hi_wr)
        |-> busy_n == asq_pkg::LEN_TAB[hi_rdata[6:5]]) else $error("select length");
    a_scan_last: assert property ($rose(irq_ctrl_rdata[0]) && !$past(irq_ctrl_wr)
        |-> $past(fe_chan) == 3'h7) else $error("scan done early");
    a_scan_step: assert property ($changed(fe_chan) && lo_rdata[4] && !hi_rdata[4]
        && !$past(hi_rdata[4]) && !$past(lo_wr) && $past(fe_chan) != 3'h7
        |-> fe_chan == 3'($past(fe_chan) + 3'h1)) else $error("scan order");
endmodule : asq_seq_asserts
`default_nettype wire

// ---- verif/asq_fe_model.sv ----
// Behavioural analog front end answering the sequencer
`default_nettype none
module asq_fe_model (
    input wire logic [2:0] chan,
    input wire logic [3:0] stamp,
    output logic [9:0] result
);
    timeunit 1ns;
    timeprecision 1ns;
    // Level tied to channel and a bench stamp, so stale results show
    assign result = {stamp, chan, chan};
endmodule : asq_fe_model
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the scan/select sequencer
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, rst, hi_wr, lo_wr, irq_ctrl_wr, irq_req_clear, conv_irq_enable;
    logic [7:0] hi_wdata, lo_wdata, irq_ctrl_wdata, hi_rdata, lo_rdata, irq_ctrl_rdata;
    logic conv_irq_request, conv_irq_out, fe_sample, fe_convert;
    logic [1:0] conv_irq_prio, prio;
    logic [15:0] conv_irq_vector;
    logic [9:0] fe_result;
    logic [2:0] fe_chan;
    logic [3:0] stamp;
    logic [9:0] res [0:7];
    logic [9:0] expv [0:7];
    int num_errors, num_checks;
    asq_sequencer dut (.clock, .rst, .hi_wr, .hi_wdata, .hi_rdata, .lo_wr, .lo_wdata,
        .lo_rdata, .irq_ctrl_wr, .irq_ctrl_wdata, .irq_ctrl_rdata, .irq_req_clear,
        .conv_irq_enable, .conv_prio_bit0(prio[0]), .conv_prio_bit1(prio[1]),
        .conv_irq_request, .conv_irq_out, .conv_irq_prio, .conv_irq_vector, .fe_result,
        .fe_chan, .fe_sample, .fe_convert, .conv_result_reg(res));
    asq_fe_model fe (.chan(fe_chan), .stamp(stamp), .result(fe_result));
    task final_report();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // r: 0 high control, 1 low control, 2 irq control
    task wr(input int r, input logic [7:0] d);
        @(negedge clock);
        hi_wr = (r == 0);
        lo_wr = (r == 1);
        irq_ctrl_wr = (r == 2);
        hi_wdata = d;
        lo_wdata = d;
        irq_ctrl_wdata = d;
        @(negedge clock);
        hi_wr = 0;
        lo_wr = 0;
        irq_ctrl_wr = 0;
    endtask : wr
    // s: 0 select idle, 1 scan idle, 2 channel v, 3 scan flag set
    task wt(input int s, input logic [2:0] v);
        int n;
        n = 0;
        while (!(s == 0 ? hi_rdata[4] === 1'b0 : s == 1 ? lo_rdata[4] === 1'b0 :
                 s == 2 ? fe_chan === v : irq_ctrl_rdata[0] === 1'b1)) begin
            @(negedge clock);
            n++;
            if (n > 3000) begin
                num_errors++;
                final_report();
            end
        end
    endtask : wt
    task chk_all();
        for (int c = 0; c < 8; c++) chk("result", 16'(res[c]), 16'(expv[c]));
    endtask : chk_all
    task clr_req();
        @(negedge clock);
        irq_req_clear = 1;
        @(negedge clock);
        irq_req_clear = 0;
        chk("req_clr", 16'(conv_irq_request), 16'h0);
    endtask : clr_req
    task t_reset();
        chk("hi_rst", 16'(hi_rdata), 16'h0088);
        chk("lo_rst", 16'(lo_rdata), 16'h0088);
        chk("irq_rst", 16'(irq_ctrl_rdata), 16'h00f0);
        chk("vector", conv_irq_vector, 16'h0044);
        for (int p = 0; p < 4; p++) begin
            prio = 2'(p);
            @(negedge clock);
            chk("prio", 16'(conv_irq_prio), 16'(p));
        end
        for (int c = 0; c < 8; c++) expv[c] = 10'h000;
        chk_all();
    endtask : t_reset
    task t_select(input logic [2:0] ch, input logic [1:0] code, input logic en);
        stamp = stamp + 4'h1;
        wr(2, {4'h0, en, 3'h0});
        wr(0, {1'b0, code, 1'b1, 1'b0, ch});
        wt(0, 3'h0);
        expv[ch] = {stamp, ch, ch};
        chk_all();
        chk("single_done", 16'(irq_ctrl_rdata[1]), 16'h1);
        chk("request", 16'(conv_irq_request), 16'(en));
        chk("irq_out", 16'(conv_irq_out), 16'(en));
        clr_req();
    endtask : t_select
    task t_abort();
        stamp = stamp + 4'h1;
        wr(2, 8'h08);
        wr(0, 8'h72);
        repeat (40) @(negedge clock);
        wr(0, 8'h62);
        chk("abort_busy", 16'(hi_rdata[4]), 16'h0);
        repeat (150) @(negedge clock);
        chk("abort_flag", 16'(irq_ctrl_rdata[1]), 16'h0);
        chk_all();
    endtask : t_abort
    task t_scan_once();
        stamp = stamp + 4'h1;
        wr(2, 8'h04);
        wr(0, 8'h60);
        wr(1, 8'h15);
        wt(1, 3'h0);
        for (int c = 5; c < 8; c++) expv[c] = {stamp, 3'(c), 3'(c)};
        chk_all();
        chk("scan_done", 16'(irq_ctrl_rdata[0]), 16'h1);
        chk("scan_req", 16'(conv_irq_request), 16'h1);
        clr_req();
        chk("scan_sticky", 16'(irq_ctrl_rdata[0]), 16'h1);
    endtask : t_scan_once
    task t_preempt();
        stamp = stamp + 4'h1;
        expv[1] = {stamp, 3'h1, 3'h1};
        wr(2, 8'h0c);
        wr(1, 8'h11);
        wt(2, 3'h2);
        repeat (20) @(negedge clock);
        stamp = stamp + 4'h1;
        wr(0, 8'h76);
        wt(0, 3'h0);
        expv[6] = {stamp, 3'h6, 3'h6};
        chk_all();
        wt(1, 3'h0);
        for (int c = 2; c < 8; c++) expv[c] = {stamp, 3'(c), 3'(c)};
        chk_all();
        clr_req();
    endtask : t_preempt
    task t_overlap();
        stamp = stamp + 4'h1;
        wr(2, 8'h00);
        wr(0, 8'h73);
        // Late in the channel, so the checker's sampling count is not cut
        repeat (90) @(negedge clock);
        wr(0, 8'h75);
        chk("sel_ignored", 16'(fe_chan), 16'h3);
        wr(1, 8'h14);
        chk("scan_held", 16'(fe_chan), 16'h3);
        wt(0, 3'h0);
        expv[3] = {stamp, 3'h3, 3'h3};
        chk_all();
        chk("scan_after", 16'(fe_chan), 16'h4);
        repeat (10) @(negedge clock);
        wr(0, 8'h70);
        chk("sel_chan", 16'(fe_chan), 16'h0);
        repeat (5) @(negedge clock);
        wr(0, 8'h60);
        chk("abort_resume", 16'(fe_chan), 16'h4);
        chk("abort_run", 16'(lo_rdata[4]), 16'h1);
        wt(1, 3'h0);
        for (int c = 4; c < 8; c++) expv[c] = {stamp, 3'(c), 3'(c)};
        chk_all();
        chk("scan_flag", 16'(irq_ctrl_rdata[0]), 16'h1);
    endtask : t_overlap
    task t_repeat();
        wr(2, 8'h00);
        wr(1, 8'h56);
        wt(3, 3'h0);
        repeat (3) @(negedge clock);
        chk("wrap_chan", 16'(fe_chan), 16'h6);
        chk("wrap_run", 16'(lo_rdata[4]), 16'h1);
        wr(1, 8'h46);
        chk("halt_run", 16'(lo_rdata[4]), 16'h0);
        repeat (200) @(negedge clock);
        chk("halt_idle", 16'(fe_sample), 16'h0);
    endtask : t_repeat
    initial begin
        clock = 0;
        forever #25 clock = ~clock;
    end
    initial begin
        {rst, conv_irq_enable} = 2'b11;
        {hi_wr, lo_wr, irq_ctrl_wr, irq_req_clear} = 4'h0;
        {hi_wdata, lo_wdata, irq_ctrl_wdata} = 24'h0;
        {prio, stamp} = 6'h0;
        repeat (6) @(negedge clock);
        rst = 0;
        t_reset();
        for (int c = 0; c < 8; c++) t_select(3'(c), 2'(c % 4), 1'(c != 5));
        t_abort();
        t_scan_once();
        t_preempt();
        t_overlap();
        t_repeat();
        final_report();
    end
endmodule : testbench
bind asq_sequencer asq_seq_asserts chk_i (.clock, .rst, .hi_wr, .hi_wdata, .hi_rdata, .lo_wr,
    .lo_rdata, .irq_ctrl_wr, .irq_ctrl_rdata, .irq_req_clear, .conv_irq_enable,
    .conv_prio_bit0, .conv_prio_bit1, .conv_irq_request, .conv_irq_out, .conv_irq_prio,
    .conv_irq_vector, .fe_chan, .fe_sample, .fe_convert);
`default_nettype wire
